// file: design/mvc_calib.sv
// What this block does
// - stroke time held, 5.0 to 300.0 s
// - closed value held, 0 to FFFFF
// - open value held, 0 to FFFF
// - command takes off, close, open, auto
// - auto: close until closed, capture closed
// - then open until open, capture open
// - good auto loads measured stroke time
// - good auto returns command to off
// - failed auto sets command to error
// - failed auto leaves all values unchanged
// - normal end stores data to nonvolatile
// - estimation-only valve types refuse auto
// - error when open minus closed below 256
// - error when closed exceeds open
// - error on feedback or measurement burnout
// - error when auto exceeds 360 seconds
// - error when stroke outside 5 to 300 s
// - close command captures feedback as closed
// - open command captures feedback as open
// - manual capture skips the span check
// - manual capture leaves stroke time alone
//
// The implementer's own choices: the register addresses and the AXI4-Lite slave port.
`include "mvc_regs.svh"
`default_nettype none

module mvc_calib
#(
    parameter int unsigned TENTH_CYCLES = `MVC_TENTH_CYCLES
)
(
    // clock and reset
    input  wire logic         REF_CLK,
    input  wire logic         RST,
    // axi4-lite write
    input  wire logic [7:0]   AWADDR,
    input  wire logic         AWVALID,
    output logic              AWREADY,
    input  wire logic [31:0]  WDATA,
    input  wire logic [3:0]   WSTRB,
    input  wire logic         WVALID,
    output logic              WREADY,
    output logic [1:0]        BRESP,
    output logic              BVALID,
    input  wire logic         BREADY,
    // axi4-lite read
    input  wire logic [7:0]   ARADDR,
    input  wire logic         ARVALID,
    output logic              ARREADY,
    output logic [31:0]       RDATA,
    output logic [1:0]        RRESP,
    output logic              RVALID,
    input  wire logic         RREADY,
    // valve actuator and feedback
    input  wire logic [19:0]  POS_FB,
    input  wire logic         AT_CLOSED,
    input  wire logic         AT_OPEN,
    input  wire logic         FB_BURNOUT,
    input  wire logic         PV_BURNOUT,
    output logic              DRIVE_CLOSE,
    output logic              DRIVE_OPEN,
    // results toward estimation and storage
    output logic [11:0]       STROKE_TIME,
    output logic [19:0]       CLOSED_CAL,
    output logic [15:0]       OPEN_CAL,
    output logic              NV_STORE
);
    import mvc_pkg::*;

    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // bus slave
    logic        awready_q;
    logic        wready_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        arready_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [31:0] rdata_q;
    logic [7:0]  waddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    wire aw_hs   = AWVALID & awready_q;
    wire w_hs    = WVALID & wready_q;
    wire ar_hs   = ARVALID & arready_q;
    wire wr_fire = ~awready_q & ~wready_q & ~bvalid_q;

    // ==========================================================
    // calibration state
    mvc_state_t state_q;
    mvc_state_t state_d;
    mvc_cmd_t   cmd_q;
    mvc_cmd_t   cmd_d;
    mvc_vtype_t vtype_q;
    logic [11:0] stroke_q;
    logic [19:0] closed_q;
    logic [15:0] open_q;
    logic [19:0] cap_closed_q;
    logic [15:0] cap_open_q;
    logic [11:0] elapsed_q;
    logic [11:0] meas_q;
    logic [22:0] tick_cnt_q;
    logic        close_q;
    logic        open_drv_q;
    logic        nv_q;

    wire [31:0] wmerged  = merge_strb(32'h00000000, wdata_q, wstrb_q);
    wire [31:0] wclosed  = merge_strb({12'h000, closed_q}, wdata_q, wstrb_q);
    wire [31:0] wopen    = merge_strb({16'h0000, open_q}, wdata_q, wstrb_q);
    wire        wr_cmd   = wr_fire & (waddr_q == `MVC_OFF_COMMAND) & wstrb_q[0];
    wire [2:0]  wcmd     = wdata_q[`MVC_CMD_LSB +: 3];
    wire        busy     = (state_q != MVC_ST_IDLE);
    wire        est_only = (vtype_q == MVC_VT_EST_ONE) | (vtype_q == MVC_VT_EST_TWO);
    wire        idle_wr  = wr_fire & ~busy;
    wire [11:0] wstroke  = wmerged[11:0];

    wire req_auto  = wr_cmd & (wcmd == MVC_CMD_AUTO) & ~busy & ~est_only;
    wire req_close = wr_cmd & (wcmd == MVC_CMD_CLOSE) & ~busy;
    wire req_open  = wr_cmd & (wcmd == MVC_CMD_OPEN) & ~busy;
    wire req_abort = wr_cmd & (wcmd == MVC_CMD_OFF) & busy;

    wire tick      = busy & (tick_cnt_q == 23'(TENTH_CYCLES - 1));
    wire burnout   = FB_BURNOUT | PV_BURNOUT;
    wire timed_out = elapsed_q >= `MVC_TIMEOUT_TENTH;
    wire run_err   = busy & (burnout | timed_out);

    // end-of-sequence checks on the captured pair and the measured stroke time
    wire [20:0] cap_open_w = {5'h00, cap_open_q};
    wire [20:0] cap_clo_w  = {1'b0, cap_closed_q};
    wire inverted  = cap_clo_w > cap_open_w;
    wire narrow    = ~inverted & ((cap_open_w - cap_clo_w) < `MVC_MIN_SPAN);
    wire bad_time  = (meas_q < `MVC_STROKE_MIN) | (meas_q > `MVC_STROKE_MAX);
    wire check_bad = inverted | narrow | bad_time;
    wire commit    = (state_q == MVC_ST_CHECK) & ~check_bad & ~run_err;
    wire fail      = run_err | ((state_q == MVC_ST_CHECK) & check_bad);

    // ==========================================================
    // sequencer
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            MVC_ST_IDLE:
            begin
                if (req_auto)
                    state_d = MVC_ST_CLOSING;
            end
            MVC_ST_CLOSING:
            begin
                if (AT_CLOSED)
                    state_d = MVC_ST_OPENING;
            end
            MVC_ST_OPENING:
            begin
                if (AT_OPEN)
                    state_d = MVC_ST_CHECK;
            end
            MVC_ST_CHECK:
            begin
                state_d = MVC_ST_IDLE;
            end
            default:
            begin
                state_d = MVC_ST_IDLE;
            end
        endcase
        // error before abort so a failure in the write cycle still shows
        if (fail | req_abort)
            state_d = MVC_ST_IDLE;
    end

    always_comb
    begin
        cmd_d = cmd_q;
        if (fail)
            cmd_d = MVC_CMD_ERR;
        else if (commit)
            cmd_d = MVC_CMD_OFF;
        else if (req_abort)
            cmd_d = MVC_CMD_OFF;
        else if (req_auto)
            cmd_d = MVC_CMD_AUTO;
        else if (wr_cmd & ~busy)
            cmd_d = MVC_CMD_OFF;
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            state_q    <= MVC_ST_IDLE;
            cmd_q      <= MVC_CMD_OFF;
            close_q    <= 1'b0;
            open_drv_q <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            cmd_q      <= cmd_d;
            close_q    <= (state_d == MVC_ST_CLOSING);
            open_drv_q <= (state_d == MVC_ST_OPENING);
        end
    end

    // timing counts run only while a sequence is under way
    always_ff @(posedge REF_CLK)
    begin
        if (RST | ~busy)
        begin
            tick_cnt_q <= 23'h000000;
            elapsed_q  <= 12'h000;
            meas_q     <= 12'h000;
        end
        else if (tick)
        begin
            tick_cnt_q <= 23'h000000;
            elapsed_q  <= elapsed_q + 12'h001;
            if (state_q == MVC_ST_OPENING)
                meas_q <= meas_q + 12'h001;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_q + 23'h000001;
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            cap_closed_q <= 20'h00000;
            cap_open_q   <= 16'h0000;
        end
        else
        begin
            if ((state_q == MVC_ST_CLOSING) & AT_CLOSED)
                cap_closed_q <= POS_FB;
            if ((state_q == MVC_ST_OPENING) & AT_OPEN)
                cap_open_q <= POS_FB[15:0];
        end
    end

    // ==========================================================
    // calibration results; software writes are held off while busy
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            stroke_q <= `MVC_RST_STROKE;
            closed_q <= `MVC_RST_CLOSED;
            open_q   <= `MVC_RST_OPEN;
            vtype_q  <= MVC_VT_FEEDBACK;
            nv_q     <= 1'b0;
        end
        else
        begin
            nv_q <= commit | req_close | req_open;
            if (commit)
            begin
                stroke_q <= meas_q;
                closed_q <= cap_closed_q;
                open_q   <= cap_open_q;
            end
            if (req_close)
                closed_q <= POS_FB;
            if (req_open)
                open_q <= POS_FB[15:0];
            // out-of-range stroke writes are dropped, not clamped
            if (idle_wr & (waddr_q == `MVC_OFF_STROKE) & (wstroke >= `MVC_STROKE_MIN)
                & (wstroke <= `MVC_STROKE_MAX))
                stroke_q <= wstroke;
            if (idle_wr & (waddr_q == `MVC_OFF_CLOSED))
                closed_q <= wclosed[19:0];
            if (idle_wr & (waddr_q == `MVC_OFF_OPEN))
                open_q <= wopen[15:0];
            if (idle_wr & (waddr_q == `MVC_OFF_VTYPE) & wstrb_q[0])
                vtype_q <= mvc_vtype_t'(wdata_q[1:0]);
        end
    end

    // ==========================================================
    // bus channels
    wire w_known = (waddr_q == `MVC_OFF_COMMAND) | (waddr_q == `MVC_OFF_STROKE)
                 | (waddr_q == `MVC_OFF_CLOSED) | (waddr_q == `MVC_OFF_OPEN)
                 | (waddr_q == `MVC_OFF_VTYPE);

    logic [31:0] rd_word;
    logic        rd_ok;
    always_comb
    begin
        rd_ok = 1'b1;
        case (ARADDR)
            `MVC_OFF_COMMAND:  rd_word = {29'h00000000, cmd_q};
            `MVC_OFF_STROKE:   rd_word = {20'h00000, stroke_q};
            `MVC_OFF_CLOSED:   rd_word = {12'h000, closed_q};
            `MVC_OFF_OPEN:     rd_word = {16'h0000, open_q};
            `MVC_OFF_VTYPE:    rd_word = {30'h00000000, vtype_q};
            `MVC_OFF_STATUS:   rd_word = {26'h0000000, AT_OPEN, AT_CLOSED, state_q};
            `MVC_OFF_FEEDBACK: rd_word = {12'h000, POS_FB};
            default:
            begin
                rd_word = 32'h00000000;
                rd_ok   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= 2'h0;
            waddr_q   <= 8'h00;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
        end
        else
        begin
            if (aw_hs)
            begin
                awready_q <= 1'b0;
                waddr_q   <= AWADDR;
            end
            if (w_hs)
            begin
                wready_q <= 1'b0;
                wdata_q  <= WDATA;
                wstrb_q  <= WSTRB;
            end
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q  <= w_known ? 2'h0 : 2'h2;
            end
            if (bvalid_q & BREADY)
            begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= 2'h0;
            rdata_q   <= 32'h00000000;
        end
        else if (ar_hs)
        begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rd_word;
            rresp_q   <= rd_ok ? 2'h0 : 2'h2;
        end
        else if (rvalid_q & RREADY)
        begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign AWREADY     = awready_q;
    assign WREADY      = wready_q;
    assign BVALID      = bvalid_q;
    assign BRESP       = bresp_q;
    assign ARREADY     = arready_q;
    assign RVALID      = rvalid_q;
    assign RRESP       = rresp_q;
    assign RDATA       = rdata_q;
    assign DRIVE_CLOSE = close_q;
    assign DRIVE_OPEN  = open_drv_q;
    assign STROKE_TIME = stroke_q;
    assign CLOSED_CAL  = closed_q;
    assign OPEN_CAL    = open_q;
    assign NV_STORE    = nv_q;

    // ==========================================================
    // checks
    chk_drive_exclusive: assert property (@(posedge REF_CLK) disable iff (RST)
        !(close_q && open_drv_q)) else $error("open and close driven together");

    chk_auto_closes: assert property (@(posedge REF_CLK) disable iff (RST)
        req_auto |=> close_q && !open_drv_q && cmd_q == MVC_CMD_AUTO)
        else $error("auto start did not drive close");

    chk_abort_stops: assert property (@(posedge REF_CLK) disable iff (RST)
        req_abort && !fail |=> !close_q && !open_drv_q && cmd_q == MVC_CMD_OFF
        && $stable(stroke_q)) else $error("abort did not stop sequence");

    chk_refuse_estim: assert property (@(posedge REF_CLK) disable iff (RST)
        wr_cmd && wcmd == MVC_CMD_AUTO && est_only && !busy
        |=> cmd_q == MVC_CMD_OFF && !close_q [*2]) else $error("auto not refused");

    chk_fail_keeps: assert property (@(posedge REF_CLK) disable iff (RST)
        fail && !idle_wr |=> cmd_q == MVC_CMD_ERR && $stable(stroke_q)
        && $stable(closed_q) && $stable(open_q) && !close_q && !open_drv_q)
        else $error("failed run changed values or kept driving");

    chk_commit_loads: assert property (@(posedge REF_CLK) disable iff (RST)
        commit |=> stroke_q == $past(meas_q) && open_q == $past(cap_open_q)
        && cmd_q == MVC_CMD_OFF && nv_q) else $error("good run not committed");

    chk_span_error: assert property (@(posedge REF_CLK) disable iff (RST)
        state_q == MVC_ST_CHECK && !inverted
        && ({5'h00, cap_open_q} - {1'b0, cap_closed_q}) < 21'h00100
        |=> cmd_q == MVC_CMD_ERR) else $error("narrow span accepted");

    chk_manual_close: assert property (@(posedge REF_CLK) disable iff (RST)
        req_close |=> closed_q == $past(POS_FB) && cmd_q == MVC_CMD_OFF && nv_q
        && $stable(stroke_q)) else $error("manual close capture wrong");

    chk_burnout_err: assert property (@(posedge REF_CLK) disable iff (RST)
        busy && burnout |=> cmd_q == MVC_CMD_ERR && state_q == MVC_ST_IDLE)
        else $error("burnout did not end run in error");

    chk_timeout_err: assert property (@(posedge REF_CLK) disable iff (RST)
        busy && elapsed_q == 12'hE10 |=> cmd_q == MVC_CMD_ERR)
        else $error("run passed the time limit");

endmodule

`default_nettype wire

// file: design/mvc_pkg.sv
`default_nettype none

package mvc_pkg;

    typedef enum logic [2:0] {
        MVC_CMD_OFF   = 3'h0,
        MVC_CMD_CLOSE = 3'h1,
        MVC_CMD_OPEN  = 3'h2,
        MVC_CMD_AUTO  = 3'h3,
        MVC_CMD_ERR   = 3'h4
    } mvc_cmd_t;

    typedef enum logic [3:0] {
        MVC_ST_IDLE    = 4'h1,
        MVC_ST_CLOSING = 4'h2,
        MVC_ST_OPENING = 4'h4,
        MVC_ST_CHECK   = 4'h8
    } mvc_state_t;

    typedef enum logic [1:0] {
        MVC_VT_FEEDBACK  = 2'h0,
        MVC_VT_FB_EST    = 2'h1,
        MVC_VT_EST_ONE   = 2'h2,
        MVC_VT_EST_TWO   = 2'h3
    } mvc_vtype_t;

endpackage

`default_nettype wire

// file: design/mvc_regs.svh
`ifndef MVC_REGS_SVH
`define MVC_REGS_SVH

// ==========================================================
// register offsets (byte addresses)
`define MVC_OFF_COMMAND   8'h00
`define MVC_OFF_STROKE    8'h04
`define MVC_OFF_CLOSED    8'h08
`define MVC_OFF_OPEN      8'h0C
`define MVC_OFF_VTYPE     8'h10
`define MVC_OFF_STATUS    8'h14
`define MVC_OFF_FEEDBACK  8'h18

// ==========================================================
// field positions
`define MVC_CMD_LSB       0
`define MVC_STAT_STATE    0
`define MVC_STAT_AT_CLO   4
`define MVC_STAT_AT_OPN   5

// ==========================================================
// reset values
`define MVC_RST_STROKE    12'h12C
`define MVC_RST_CLOSED    20'h00000
`define MVC_RST_OPEN      16'hFFFF

// ==========================================================
// limits and timing, stroke in tenths of a second
`define MVC_STROKE_MIN    12'h032
`define MVC_STROKE_MAX    12'hBB8
`define MVC_TIMEOUT_S     360
`define MVC_TIMEOUT_TENTH 12'hE10
`define MVC_MIN_SPAN      21'h00100
`define MVC_CLK_NS        20
`define MVC_TENTH_NS      100000000
`define MVC_TENTH_CYCLES  (`MVC_TENTH_NS / `MVC_CLK_NS)

`endif

// file: tb/mvc_calib_bench.sv
`include "mvc_regs.svh"
`default_nettype none

module mvc_calib_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import mvc_pkg::*;

    localparam int TC = 4;

    // ==========================================================
    // signals
    logic        ref_clk = 1'h0;
    logic        rst = 1'h1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd, rs;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [19:0] pos_fb, closed_cal, fb_closed = 20'h01000, fb_open = 20'h01100;
    logic        at_closed, at_open, drive_close, drive_open, nv_store;
    logic        fb_burnout = 1'h0, pv_burnout = 1'h0, load = 1'h0;
    logic [11:0] stroke_time;
    logic [15:0] open_cal;
    int          travel = 400, start_pos = 200;
    int          bad_count = 0, n_tests = 0, cycles = 0, nv_count = 0;

    always #10 ref_clk = ~ref_clk;

    mvc_calib #(.TENTH_CYCLES(TC)) i_dut (
        .REF_CLK(ref_clk), .RST(rst),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .POS_FB(pos_fb), .AT_CLOSED(at_closed), .AT_OPEN(at_open),
        .FB_BURNOUT(fb_burnout), .PV_BURNOUT(pv_burnout),
        .DRIVE_CLOSE(drive_close), .DRIVE_OPEN(drive_open),
        .STROKE_TIME(stroke_time), .CLOSED_CAL(closed_cal), .OPEN_CAL(open_cal),
        .NV_STORE(nv_store));

    mvc_valve_model i_valve (
        .clk(ref_clk), .rst(rst), .drv_close(drive_close), .drv_open(drive_open),
        .load(load), .travel(travel), .start_pos(start_pos),
        .fb_closed(fb_closed), .fb_open(fb_open),
        .pos_fb(pos_fb), .at_closed(at_closed), .at_open(at_open));

    // ==========================================================
    // bench services
    task automatic close_out();
        if (bad_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // whole run is near 29000 cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (nv_store === 1'h1)
            nv_count++;
        if (cycles >= 90000)
        begin
            bad_count++;
            close_out();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge ref_clk);
            n++;
            if (awready)
                awvalid <= 1'h0;
            if (wready)
                wvalid <= 1'h0;
        end while (!bvalid && n < 100);
        rs = {30'h0, bresp};
        bready <= 1'h0;
        check("write answer", n < 100, 32'h1);
    endtask

    task automatic rd_reg(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do
        begin
            @(posedge ref_clk);
            n++;
            if (arready)
                arvalid <= 1'h0;
        end while (!rvalid && n < 100);
        rd = rdata;
        rs = {30'h0, rresp};
        rready <= 1'h0;
        check("read answer", n < 100, 32'h1);
    endtask

    // waits for the drive pair to reach a value, bounded above the timeout
    task automatic wait_drv(input logic [1:0] stop);
        int n;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while ({drive_close, drive_open} !== stop && n < 20000);
        check("drive wait", n < 20000, 32'h1);
    endtask

    task automatic set_valve(input int trav, input int sp, input logic [19:0] fc, fo);
        @(posedge ref_clk);
        travel <= trav;
        start_pos <= sp;
        fb_closed <= fc;
        fb_open <= fo;
        load <= 1'h1;
        @(posedge ref_clk);
        load <= 1'h0;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [11:0] sv [4] = '{12'h031, 12'h032, 12'hBB8, 12'hBB9};
        logic [11:0] ex [4] = '{12'h12C, 12'h032, 12'hBB8, 12'hBB8};
        rd_reg(`MVC_OFF_STROKE);
        check("stroke reset", rd, 32'h12C);
        rd_reg(`MVC_OFF_CLOSED);
        check("closed reset", rd, 32'h0);
        rd_reg(`MVC_OFF_OPEN);
        check("open reset", rd, 32'hFFFF);
        rd_reg(`MVC_OFF_COMMAND);
        check("command reset", rd, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            wr(`MVC_OFF_STROKE, {20'h0, sv[i]});
            check("stroke limits", {20'h0, stroke_time}, {20'h0, ex[i]});
        end
        wr(`MVC_OFF_CLOSED, 32'hFFFFFFFF);
        check("closed width", {12'h0, closed_cal}, 32'hFFFFF);
        wr(`MVC_OFF_OPEN, 32'hFFFFFFFF);
        check("open width", {16'h0, open_cal}, 32'hFFFF);
        rd_reg(8'h1C);
        check("unmapped read", rs, 32'h2);
        wr(8'h1C, 32'h0);
        check("unmapped write", rs, 32'h2);
    endtask

    task automatic t_auto_ok();
        int n0;
        set_valve(400, 200, 20'h01000, 20'h01100);
        n0 = nv_count;
        wr(`MVC_OFF_COMMAND, {29'h0, MVC_CMD_AUTO});
        check("closing first", {drive_close, drive_open}, 32'h2);
        wait_drv(2'h1);
        check("open after closure", at_closed, 32'h1);
        wait_drv(2'h0);
        repeat (4) @(posedge ref_clk);
        check("closed capture", {12'h0, closed_cal}, 32'h01000);
        check("open capture", {16'h0, open_cal}, 32'h1100);
        check("stroke measured", stroke_time >= 99 && stroke_time <= 101, 32'h1);
        rd_reg(`MVC_OFF_COMMAND);
        check("command after auto", rd, 32'h0);
        check("store pulse", nv_count - n0, 32'h1);
    endtask

    task automatic run_err(input int trav, input int sp, input logic [19:0] fc, fo,
                           input int lo, input int hi);
        int n0;
        int c0;
        logic [11:0] st;
        set_valve(trav, sp, fc, fo);
        n0 = nv_count;
        st = stroke_time;
        wr(`MVC_OFF_COMMAND, {29'h0, MVC_CMD_AUTO});
        c0 = cycles;
        wait_drv(2'h0);
        check("abnormal end time", cycles - c0 >= lo && cycles - c0 <= hi, 32'h1);
        repeat (4) @(posedge ref_clk);
        rd_reg(`MVC_OFF_COMMAND);
        check("error command", rd, {29'h0, MVC_CMD_ERR});
        check("closed kept", {12'h0, closed_cal}, 32'h01000);
        check("open kept", {16'h0, open_cal}, 32'h1100);
        check("stroke kept", {20'h0, stroke_time}, {20'h0, st});
        check("no store", nv_count - n0, 32'h0);
        wr(`MVC_OFF_COMMAND, 32'h0);
        rd_reg(`MVC_OFF_COMMAND);
        check("error cleared", rd, 32'h0);
    endtask

    task automatic t_burn();
        for (int i = 0; i < 2; i++)
        begin
            set_valve(400, 200, 20'h01000, 20'h01100);
            wr(`MVC_OFF_COMMAND, {29'h0, MVC_CMD_AUTO});
            repeat (20) @(posedge ref_clk);
            fb_burnout <= (i == 0);
            pv_burnout <= (i == 1);
            repeat (2) @(posedge ref_clk);
            check("drives on burnout", {drive_close, drive_open}, 32'h0);
            fb_burnout <= 1'h0;
            pv_burnout <= 1'h0;
            rd_reg(`MVC_OFF_COMMAND);
            check("burnout command", rd, {29'h0, MVC_CMD_ERR});
            wr(`MVC_OFF_COMMAND, 32'h0);
        end
    endtask

    task automatic t_abort();
        set_valve(400, 200, 20'h01000, 20'h01100);
        wr(`MVC_OFF_COMMAND, {29'h0, MVC_CMD_AUTO});
        repeat (20) @(posedge ref_clk);
        wr(`MVC_OFF_COMMAND, 32'h0);
        check("drives on abort", {drive_close, drive_open}, 32'h0);
        rd_reg(`MVC_OFF_COMMAND);
        check("abort command", rd, 32'h0);
        check("closed after abort", {12'h0, closed_cal}, 32'h01000);
    endtask

    task automatic t_vtype();
        for (int v = 2; v < 4; v++)
        begin
            wr(`MVC_OFF_VTYPE, v);
            wr(`MVC_OFF_COMMAND, {29'h0, MVC_CMD_AUTO});
            check("refused drive", drive_close, 32'h0);
            rd_reg(`MVC_OFF_COMMAND);
            check("refused command", rd, 32'h0);
        end
        wr(`MVC_OFF_VTYPE, 32'h0);
    endtask

    task automatic t_manual();
        int n0;
        logic [11:0] st;
        n0 = nv_count;
        st = stroke_time;
        set_valve(400, 0, 20'h00ABC, 20'h00B00);
        wr(`MVC_OFF_COMMAND, {29'h0, MVC_CMD_CLOSE});
        repeat (2) @(posedge ref_clk);
        check("manual closed", {12'h0, closed_cal}, 32'h00ABC);
        rd_reg(`MVC_OFF_COMMAND);
        check("manual command", rd, 32'h0);
        set_valve(400, 400, 20'h00ABC, 20'h00B00);
        wr(`MVC_OFF_COMMAND, {29'h0, MVC_CMD_OPEN});
        repeat (2) @(posedge ref_clk);
        check("manual open", {16'h0, open_cal}, 32'h0B00);
        check("manual stroke", {20'h0, stroke_time}, {20'h0, st});
        check("manual stores", nv_count - n0, 32'h2);
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
        t_regs();
        t_auto_ok();
        run_err(400, 200, 20'h01000, 20'h010FF, 0, 100000);
        run_err(400, 200, 20'h02000, 20'h01000, 0, 100000);
        run_err(100, 0, 20'h01000, 20'h01100, 0, 100000);
        run_err(12100, 0, 20'h01000, 20'h01100, 0, 100000);
        run_err(20000, 0, 20'h01000, 20'h01100, 14390, 14410);
        t_burn();
        t_abort();
        t_vtype();
        t_manual();
        close_out();
    end
endmodule

`default_nettype wire

// file: tb/mvc_valve_model.sv
`default_nettype none

module mvc_valve_model
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // actuator drive
    input  wire logic        drv_close,
    input  wire logic        drv_open,
    // scenario setup, travel in cycles
    input  wire logic        load,
    input  wire integer      travel,
    input  wire integer      start_pos,
    input  wire logic [19:0] fb_closed,
    input  wire logic [19:0] fb_open,
    // feedback toward the block
    output logic [19:0]      pos_fb,
    output logic             at_closed,
    output logic             at_open
);
    timeunit 1ns;
    timeprecision 1ps;

    int pos_q;

    assign at_closed = (pos_q <= 0);
    assign at_open   = (pos_q >= travel);
    // mid-stroke reading differs from the closed value, and from the open value except where pos_q equals fb_closed ^ fb_open
    assign pos_fb = at_closed ? fb_closed : at_open ? fb_open : fb_closed ^ pos_q[19:0];

    always_ff @(posedge clk)
    begin
        if (rst || load)
            pos_q <= start_pos;
        else if (drv_close && !at_closed)
            pos_q <= pos_q - 1;
        else if (drv_open && !at_open)
            pos_q <= pos_q + 1;
    end
endmodule

`default_nettype wire
